// >>> rtl/qcrb_bank.sv
// Functional notes
// - two writable base address registers give bits 31..24 and 23..16
// - any write to one-shot location triggers a full module reset
// - two chain bits: none, first, last or intermediate board
// - interrupt when stored events equal 5-bit threshold; zero disables
// - status shows buffer empty, buffer full and four daughter-board type bits
// - 24-bit event counter read as low 16 and high 8 bits
// - counter counts all triggers when bit 14 set, else accepted only
// - counter clears on its reset write, soft/hard reset, data reset if relative
// - next-event write moves readout pointer to the next event
// - next-word write advances readout pointer by one word
// - auto-advance bit lets pointer move on readout, else only by writes
// - fast clear window is N/32 us plus 7 us; N at most 3f0
// - mode set writes set ones, ignore zeros; reads return contents
// - memory-test bit enters direct buffer memory access mode
// - offline bit stops the converter from doing conversions
// - data-clear bit generates data reset of buffer, pointers, and counter if bit 14 clear
// - overflowed samples are dropped unless overflow check is disabled
// - samples below threshold dropped unless threshold check disabled
// - acquisition-test bit takes buffer data from internal test FIFO
// - slide-enable bit runs sliding scale; sub bit disables subtraction
// - threshold step selects comparison against threshold x16 or x2
// - empty event writes nothing unless empty-event bit writes header/trailer
// - mode clear location clears every mode bit written as one
`timescale 1ns/1ps
`default_nettype none
module qcrb_bank
	import qcrb_pkg::*;
(
	input  wire logic                             core_clk,
	input  wire logic                             resetn,
	input  wire logic [15:0]                      reg_addr,
	input  wire logic [15:0]                      reg_wdata,
	input  wire logic                             reg_wr,
	input  wire logic                             reg_rd,
	output logic      [15:0]                      reg_rdata,
	output logic                                  reg_ack,
	input  wire logic                             sw_reset,
	input  wire logic                             trigger,
	input  wire logic                             trigger_accepted,
	input  wire logic [qcrb_pkg::STORED_W-1:0]    stored_events,
	input  wire logic                             buffer_empty,
	input  wire logic                             buffer_full,
	input  wire logic [qcrb_pkg::TYPE_W-1:0]      piggyback_type_pins,
	input  wire logic                             sample_valid,
	input  wire logic [qcrb_pkg::SAMPLE_W-1:0]    sample_value,
	input  wire logic [qcrb_pkg::CH_THR_W-1:0]    sample_threshold,
	input  wire logic                             sample_overflow,
	input  wire logic                             event_end,
	input  wire logic                             event_has_channels,
	input  wire logic                             convert_req,
	output logic      [qcrb_pkg::BASE_ADDRESS_DECODER_W-1:0]      base_address_decoder_high,
	output logic      [qcrb_pkg::BASE_ADDRESS_DECODER_W-1:0]      base_address_decoder_low,
	output logic                                  module_reset,
	output logic                                  chain_first,
	output logic                                  chain_last,
	output logic                                  irq_req,
	output logic                                  next_event_strobe,
	output logic                                  next_word_strobe,
	output logic                                  pointer_auto_advance,
	output logic      [qcrb_pkg::FC_CYC_W-1:0]    fast_clear_window_cycles,
	output logic                                  mem_test_mode,
	output logic                                  converter_offline,
	output logic                                  data_reset,
	output logic                                  overflow_check_disable,
	output logic                                  threshold_check_disable,
	output logic                                  acquisition_test,
	output logic                                  sliding_scale_enable,
	output logic                                  slide_sub_disable,
	output logic                                  threshold_step_select,
	output logic                                  empty_event_enable,
	output logic                                  count_every_trigger,
	output logic                                  sample_store,
	output logic                                  empty_frame_write,
	output logic                                  convert_start
);
	import qcrb_pkg::*;

	function automatic logic wr_at(input logic wr, input logic [15:0] a, input logic [15:0] b);
		return wr && (a == b);
	endfunction

	// ========================================================
	// storage
	logic [BASE_ADDRESS_DECODER_W-1:0]   base_hi_reg;
	logic [BASE_ADDRESS_DECODER_W-1:0]   base_lo_reg;
	logic                mod_reset_reg;
	logic [1:0]          chain_reg;
	logic [THR_W-1:0]    thr_reg;
	logic [EVCNT_W-1:0]  evcnt_reg;
	logic [FCW_W-1:0]    fcw_reg;
	logic [15:0]         mode_reg;
	logic [15:0]         mode_next;
	logic [TYPE_W-1:0]   type_sync;
	logic                evcnt_clr;
	logic [14:0]         fc_prod;
	logic [SAMPLE_W-1:0] thr_scaled;
	logic                sample_keep;

	qcrb_pin_sync #(
		.W(TYPE_W)
	) u_type_sync (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.pin_in    (piggyback_type_pins),
		.level_out (type_sync)
	);

	// ========================================================
	// one-shot reset: a single cycle pulse, then base, chain, threshold, window and counter registers clear and mode reloads MODE_RESET
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			mod_reset_reg <= 1'b0;
		else
			mod_reset_reg <= wr_at(reg_wr, reg_addr, ADDR_ONE_SHOT);
	end
	assign module_reset = mod_reset_reg;

	// ========================================================
	// base address, chain, threshold and fast clear window
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			base_hi_reg <= '0;
			base_lo_reg <= '0;
		end else if (mod_reset_reg) begin
			base_hi_reg <= '0;
			base_lo_reg <= '0;
		end else begin
			if (wr_at(reg_wr, reg_addr, ADDR_BASE_HIGH))
				base_hi_reg <= reg_wdata[BASE_ADDRESS_DECODER_W-1:0];
			if (wr_at(reg_wr, reg_addr, ADDR_BASE_LOW))
				base_lo_reg <= reg_wdata[BASE_ADDRESS_DECODER_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			chain_reg <= 2'h0;
		else if (mod_reset_reg)
			chain_reg <= 2'h0;
		else if (wr_at(reg_wr, reg_addr, ADDR_CHAIN))
			chain_reg <= {reg_wdata[CHAIN_LAST_BIT], reg_wdata[CHAIN_FIRST_BIT]};
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			thr_reg <= '0;
		else if (mod_reset_reg)
			thr_reg <= '0;
		else if (wr_at(reg_wr, reg_addr, ADDR_IRQ_THR))
			thr_reg <= reg_wdata[THR_W-1:0];
	end

	// window values above 3f0 in bits 9..0 are held at the limit; bits above 9 are dropped
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			fcw_reg <= '0;
		else if (mod_reset_reg)
			fcw_reg <= '0;
		else if (wr_at(reg_wr, reg_addr, ADDR_FAST_CLEAR))
			fcw_reg <= (reg_wdata[FCW_W-1:0] > FCW_MAX) ? FCW_MAX : reg_wdata[FCW_W-1:0];
	end

	// window in core clocks: 7 us base plus N steps of 1/32 us
	// reset value is the N = 0 window, so it never reads below the base
	assign fc_prod = 15'(fcw_reg * 15'(FC_STEP_MUL));
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			fast_clear_window_cycles <= 11'(FC_BASE_CYC);
		else
			fast_clear_window_cycles <= 11'(FC_BASE_CYC) + fc_prod[14:FC_STEP_SHIFT];
	end

	// ========================================================
	// mode register: set location ors in, clear location masks out
	always_comb begin
		mode_next = mode_reg;
		if (wr_at(reg_wr, reg_addr, ADDR_MODE_SET))
			mode_next = mode_reg | (reg_wdata & MODE_MASK);
		if (wr_at(reg_wr, reg_addr, ADDR_MODE_CLR))
			mode_next = mode_reg & ~(reg_wdata & MODE_MASK);
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			mode_reg <= MODE_RESET;
		else if (mod_reset_reg)
			mode_reg <= MODE_RESET;
		else
			mode_reg <= mode_next;
	end

	assign mem_test_mode           = mode_reg[MB_TEST_MEM];
	assign converter_offline       = mode_reg[MB_OFFLINE];
	assign data_reset              = mode_reg[MB_DATA_CLR];
	assign overflow_check_disable  = mode_reg[MB_OVF_DIS];
	assign threshold_check_disable = mode_reg[MB_THR_DIS];
	assign acquisition_test        = mode_reg[MB_ACQ_TEST];
	assign sliding_scale_enable    = mode_reg[MB_SLIDE_EN];
	assign slide_sub_disable       = mode_reg[MB_SLIDE_SUB];
	assign threshold_step_select   = mode_reg[MB_THRESHOLD_STEP_SELECT];
	assign pointer_auto_advance    = mode_reg[MB_POINTER_AUTO_ADVANCE];
	assign empty_event_enable      = mode_reg[MB_EMPTY_EN];
	assign count_every_trigger     = mode_reg[MB_COUNT_EVERY_TRIGGER];
	assign base_address_decoder_high = base_hi_reg;
	assign base_address_decoder_low  = base_lo_reg;
	assign chain_first = chain_reg[0];
	assign chain_last  = chain_reg[1];

	// ========================================================
	// event counter
	// relative counting also loses its count while data reset is held
	assign evcnt_clr = mod_reset_reg || sw_reset
		|| wr_at(reg_wr, reg_addr, ADDR_EVCNT_RST)
		|| (mode_reg[MB_DATA_CLR] && !mode_reg[MB_COUNT_EVERY_TRIGGER]);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			evcnt_reg <= '0;
		else if (evcnt_clr)
			evcnt_reg <= '0;
		else if (mode_reg[MB_COUNT_EVERY_TRIGGER] ? trigger : trigger_accepted)
			evcnt_reg <= evcnt_reg + 24'h1;
	end

	// ========================================================
	// interrupt request, level while count matches threshold
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			irq_req <= 1'b0;
		else
			irq_req <= (thr_reg != '0) && (stored_events == {1'b0, thr_reg});
	end

	// ========================================================
	// readout pointer strobes; pointer itself lives in the buffer logic
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			next_event_strobe <= 1'b0;
			next_word_strobe  <= 1'b0;
		end else begin
			next_event_strobe <= wr_at(reg_wr, reg_addr, ADDR_NEXT_EVENT);
			next_word_strobe  <= wr_at(reg_wr, reg_addr, ADDR_NEXT_WORD);
		end
	end

	// ========================================================
	// sample filtering, empty events, conversion gating
	assign thr_scaled = mode_reg[MB_THRESHOLD_STEP_SELECT]
		? SAMPLE_W'({sample_threshold, 1'b0})
		: SAMPLE_W'({sample_threshold, 4'h0});
	assign sample_keep = (mode_reg[MB_OVF_DIS] || !sample_overflow)
		&& (mode_reg[MB_THR_DIS] || (sample_value >= thr_scaled));

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sample_store      <= 1'b0;
			empty_frame_write <= 1'b0;
			convert_start     <= 1'b0;
		end else begin
			sample_store      <= sample_valid && sample_keep;
			empty_frame_write <= event_end && !event_has_channels && mode_reg[MB_EMPTY_EN];
			convert_start     <= convert_req && !mode_reg[MB_OFFLINE];
		end
	end

	// ========================================================
	// register read port, answer one cycle after the request
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 16'h0000;
			reg_ack   <= 1'b0;
		end else begin
			reg_ack   <= reg_wr || reg_rd;
			reg_rdata <= 16'h0000;
			if (reg_rd) begin
				case (reg_addr)
					ADDR_BASE_HIGH:  reg_rdata <= 16'(base_hi_reg);
					ADDR_BASE_LOW:   reg_rdata <= 16'(base_lo_reg);
					ADDR_IRQ_THR:    reg_rdata <= 16'(thr_reg);
					ADDR_BUF_STATUS: begin
						reg_rdata[ST_EMPTY_BIT] <= buffer_empty;
						reg_rdata[ST_FULL_BIT]  <= buffer_full;
						reg_rdata[ST_TYPE_LSB +: TYPE_W] <= type_sync;
					end
					ADDR_EVCNT_LO:   reg_rdata <= evcnt_reg[15:0];
					ADDR_EVCNT_HI:   reg_rdata <= 16'(evcnt_reg[23:16]);
					ADDR_FAST_CLEAR: reg_rdata <= 16'(fcw_reg);
					ADDR_MODE_SET:   reg_rdata <= mode_reg;
					default:         reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// ========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_oneshot;
		reg_wr && reg_addr == ADDR_ONE_SHOT;
	endsequence
	sequence s_mode_set;
		reg_wr && reg_addr == ADDR_MODE_SET && !mod_reset_reg;
	endsequence
	sequence s_mode_clr;
		reg_wr && reg_addr == ADDR_MODE_CLR && !mod_reset_reg;
	endsequence
	sequence s_next_event;
		reg_wr && reg_addr == ADDR_NEXT_EVENT ##1 !(reg_wr && reg_addr == ADDR_NEXT_EVENT);
	endsequence

	a_oneshot_reset: assert property (
		s_oneshot |=> module_reset ##1 (mode_reg == MODE_RESET && evcnt_reg == '0))
		else $error("one-shot write did not reset the module");
	a_chain_decode: assert property (
		reg_wr && reg_addr == ADDR_CHAIN && !mod_reset_reg
		|=> chain_first == $past(reg_wdata[0]) && chain_last == $past(reg_wdata[1]))
		else $error("chain position bits not taken");
	a_irq_match: assert property (
		thr_reg != '0 && stored_events == {1'b0, thr_reg} |=> irq_req)
		else $error("no interrupt at threshold match");
	a_irq_disabled: assert property (
		thr_reg == '0 [*2] |-> !irq_req)
		else $error("interrupt raised with zero threshold");
	a_evcnt_step: assert property (
		!evcnt_clr && mode_reg[MB_COUNT_EVERY_TRIGGER] && trigger |=> evcnt_reg == $past(evcnt_reg) + 24'h1)
		else $error("counter missed a trigger");
	a_evcnt_clear: assert property (
		reg_wr && reg_addr == ADDR_EVCNT_RST |=> evcnt_reg == '0)
		else $error("counter not cleared");
	a_mode_set: assert property (
		s_mode_set |=> mode_reg == ($past(mode_reg) | ($past(reg_wdata) & MODE_MASK)))
		else $error("mode set write wrong");
	a_mode_clear: assert property (
		s_mode_clr |=> mode_reg == ($past(mode_reg) & ~($past(reg_wdata) & MODE_MASK)))
		else $error("mode clear write wrong");
	a_fcw_limit: assert property (
		fcw_reg <= FCW_MAX && fast_clear_window_cycles >= 11'(FC_BASE_CYC))
		else $error("fast clear window out of range");
	a_next_event: assert property (
		s_next_event |-> next_event_strobe ##1 !next_event_strobe)
		else $error("next event strobe not one cycle");
	a_overflow_drop: assert property (
		sample_valid && sample_overflow && !mode_reg[MB_OVF_DIS] |=> !sample_store)
		else $error("overflowed sample stored");
	a_offline_gate: assert property (
		mode_reg[MB_OFFLINE] |=> !convert_start)
		else $error("conversion started while offline");
endmodule
`default_nettype wire

// >>> rtl/qcrb_pkg.sv
`default_nettype none
// ============================================================
// register bank constants
package qcrb_pkg;
	// ========================================================
	// register offsets
	localparam logic [15:0] ADDR_BASE_HIGH   = 16'h1012;
	localparam logic [15:0] ADDR_BASE_LOW    = 16'h1014;
	localparam logic [15:0] ADDR_ONE_SHOT    = 16'h1016;
	localparam logic [15:0] ADDR_CHAIN       = 16'h101a;
	localparam logic [15:0] ADDR_IRQ_THR     = 16'h1020;
	localparam logic [15:0] ADDR_BUF_STATUS  = 16'h1022;
	localparam logic [15:0] ADDR_EVCNT_LO    = 16'h1024;
	localparam logic [15:0] ADDR_EVCNT_HI    = 16'h1026;
	localparam logic [15:0] ADDR_NEXT_EVENT  = 16'h1028;
	localparam logic [15:0] ADDR_NEXT_WORD   = 16'h102a;
	localparam logic [15:0] ADDR_FAST_CLEAR  = 16'h102e;
	localparam logic [15:0] ADDR_MODE_SET    = 16'h1032;
	localparam logic [15:0] ADDR_MODE_CLR    = 16'h1034;
	localparam logic [15:0] ADDR_EVCNT_RST   = 16'h1040;
	// ========================================================
	// mode register fields
	localparam int MB_TEST_MEM   = 0;
	localparam int MB_OFFLINE    = 1;
	localparam int MB_DATA_CLR   = 2;
	localparam int MB_OVF_DIS    = 3;
	localparam int MB_THR_DIS    = 4;
	localparam int MB_ACQ_TEST   = 6;
	localparam int MB_SLIDE_EN   = 7;
	localparam int MB_THRESHOLD_STEP_SELECT    = 8;
	localparam int MB_POINTER_AUTO_ADVANCE  = 11;
	localparam int MB_EMPTY_EN   = 12;
	localparam int MB_SLIDE_SUB  = 13;
	localparam int MB_COUNT_EVERY_TRIGGER    = 14;
	localparam logic [15:0] MODE_MASK  = 16'h79df;
	localparam logic [15:0] MODE_RESET = 16'h4880;
	// ========================================================
	// other fields and widths
	localparam int CHAIN_FIRST_BIT = 0;
	localparam int CHAIN_LAST_BIT  = 1;
	localparam int ST_EMPTY_BIT    = 0;
	localparam int ST_FULL_BIT     = 1;
	localparam int ST_TYPE_LSB     = 4;
	localparam int TYPE_W          = 4;
	localparam int BASE_ADDRESS_DECODER_W          = 8;
	localparam int THR_W           = 5;
	localparam int STORED_W        = 6;
	localparam int EVCNT_W         = 24;
	localparam int FCW_W           = 10;
	localparam logic [9:0] FCW_MAX = 10'h3f0;
	localparam int SAMPLE_W        = 12;
	localparam int CH_THR_W        = 8;
	localparam int THR_SHIFT_COARSE = 4;
	localparam int THR_SHIFT_FINE   = 1;
	// ========================================================
	// timing
	localparam int CLK_PS        = 20000;
	localparam int FC_BASE_NS    = 7000;
	localparam int FC_BASE_CYC   = FC_BASE_NS * 1000 / CLK_PS;
	localparam int FC_STEP_PS    = 31250;
	localparam int FC_STEP_SHIFT = 4;
	localparam int FC_STEP_MUL   = FC_STEP_PS * (1 << FC_STEP_SHIFT) / CLK_PS;
	localparam int FC_CYC_W      = 11;
endpackage
`default_nettype wire

// >>> rtl/qcrb_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module qcrb_pin_sync #(
	parameter int W = 4
) (
	input  wire logic         core_clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);
	logic [W-1:0] ff1_reg;
	logic [W-1:0] ff2_reg;
	logic [W-1:0] ff3_reg;

	// ff1 feeds only ff2, so nothing sees a metastable value
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ff1_reg <= '0;
			ff2_reg <= '0;
			ff3_reg <= '0;
		end else begin
			ff1_reg <= pin_in;
			ff2_reg <= ff1_reg;
			ff3_reg <= ff2_reg;
		end
	end

	// a bit moves only once the last two stages agree
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge core_clk or negedge resetn) begin
			if (!resetn)
				level_out[i] <= 1'b0;
			else if (ff2_reg[i] == ff3_reg[i])
				level_out[i] <= ff3_reg[i];
		end
	end
endmodule
`default_nettype wire

// >>> tb/qcrb_host.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// host cpu model: one register access at a time
module qcrb_host (
	input  wire logic        core_clk,
	output logic      [15:0] reg_addr,
	output logic      [15:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_ack
);
	initial begin
		reg_addr = 16'h0;
		reg_wdata = 16'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// strobe is a one-cycle pulse; address and data held until the ack edge
	task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d, input int gap,
			output logic [15:0] q, output logic k);
		repeat (gap) @(posedge core_clk);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		k = reg_ack;
		q = reg_rdata;
		// released lines must not keep looking like the last access
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_qdc_control_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
module tb_qdc_control_register_bank;
	import qcrb_pkg::*;
	logic        core_clk, resetn, reg_wr, reg_rd, reg_ack, sw_reset, trigger, trigger_accepted;
	logic        buffer_empty, buffer_full, sample_valid, sample_overflow, event_end, event_has_channels;
	logic        convert_req, module_reset, chain_first, chain_last, irq_req, next_event_strobe;
	logic        next_word_strobe, pointer_auto_advance, mem_test_mode, converter_offline, data_reset;
	logic        overflow_check_disable, threshold_check_disable, acquisition_test, sliding_scale_enable;
	logic        slide_sub_disable, threshold_step_select, empty_event_enable, count_every_trigger;
	logic        sample_store, empty_frame_write, convert_start;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, mode, v;
	logic [23:0] cnt;
	logic [11:0] sample_value;
	logic [10:0] fast_clear_window_cycles;
	logic [7:0]  sample_threshold, base_address_decoder_high, base_address_decoder_low;
	logic [5:0]  stored_events;
	logic [3:0]  piggyback_type_pins;
	int          n_fail, n_tests;

	qcrb_bank i_dut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_ack,
		.sw_reset, .trigger, .trigger_accepted, .stored_events, .buffer_empty, .buffer_full,
		.piggyback_type_pins, .sample_valid, .sample_value, .sample_threshold, .sample_overflow,
		.event_end, .event_has_channels, .convert_req, .base_address_decoder_high,
		.base_address_decoder_low, .module_reset, .chain_first, .chain_last, .irq_req, .next_event_strobe,
		.next_word_strobe, .pointer_auto_advance, .fast_clear_window_cycles, .mem_test_mode,
		.converter_offline, .data_reset, .overflow_check_disable, .threshold_check_disable,
		.acquisition_test, .sliding_scale_enable, .slide_sub_disable, .threshold_step_select,
		.empty_event_enable, .count_every_trigger, .sample_store, .empty_frame_write, .convert_start);
	qcrb_host i_host (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_ack);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// ====
	// checking helpers
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] q;
		logic        k;
		i_host.access(1'b1, a, d, $urandom % 2, q, k);
		chk("ack", 24'h1, 24'(k));
	endtask
	task automatic rdchk(input string nm, input logic [15:0] a, input logic [15:0] e);
		logic [15:0] q;
		logic        k;
		i_host.access(1'b0, a, 16'h0, $urandom % 2, q, k);
		chk("ack", 24'h1, 24'(k));
		chk(nm, 24'(e), 24'(q));
	endtask
	// a set or clear may leave the counter held clear by data reset
	task automatic setm(input logic [15:0] s);
		wr(ADDR_MODE_SET, s & MODE_MASK);
		mode = mode | (s & MODE_MASK);
		if (mode[MB_DATA_CLR] && !mode[MB_COUNT_EVERY_TRIGGER]) cnt = '0;
	endtask
	task automatic clrm(input logic [15:0] s);
		wr(ADDR_MODE_CLR, s);
		mode = mode & ~(s & MODE_MASK);
		if (mode[MB_DATA_CLR] && !mode[MB_COUNT_EVERY_TRIGGER]) cnt = '0;
	endtask
	task automatic chkmode();
		rdchk("mode", ADDR_MODE_SET, mode);
		chk("flags", 24'({mode[MB_COUNT_EVERY_TRIGGER], mode[MB_SLIDE_SUB], mode[MB_EMPTY_EN], mode[MB_POINTER_AUTO_ADVANCE],
			mode[MB_THRESHOLD_STEP_SELECT], mode[MB_SLIDE_EN], mode[MB_ACQ_TEST], mode[MB_THR_DIS], mode[MB_OVF_DIS],
			mode[MB_DATA_CLR], mode[MB_OFFLINE], mode[MB_TEST_MEM]}), 24'({count_every_trigger,
			slide_sub_disable, empty_event_enable, pointer_auto_advance, threshold_step_select,
			sliding_scale_enable, acquisition_test, threshold_check_disable, overflow_check_disable,
			data_reset, converter_offline, mem_test_mode}));
	endtask
	// kept-sample decision worked out from the mode bits
	function automatic logic exp_keep(input logic [15:0] m, input logic [11:0] s, input logic [7:0] t,
			input logic ovf);
		return (m[MB_OVF_DIS] || !ovf) && (m[MB_THR_DIS] || int'(s) >= int'(t) * (m[MB_THRESHOLD_STEP_SELECT] ? 2 : 16));
	endfunction
	task automatic rdcnt();
		rdchk("count_lo", ADDR_EVCNT_LO, cnt[15:0]);
		rdchk("count_hi", ADDR_EVCNT_HI, {8'h0, cnt[23:16]});
	endtask
	// random datapath pulses, every cycle, outputs checked one cycle later
	task automatic dp(input int n);
		repeat (n) begin
			{trigger, trigger_accepted, sample_valid, sample_overflow, event_end, event_has_channels,
				convert_req} = 7'($urandom);
			sw_reset = ($urandom % 8) == 0;
			sample_value = 12'($urandom);
			sample_threshold = 8'($urandom);
			@(posedge core_clk);
			#1;
			if (sw_reset || (mode[MB_DATA_CLR] && !mode[MB_COUNT_EVERY_TRIGGER])) cnt = '0;
			else cnt = cnt + (mode[MB_COUNT_EVERY_TRIGGER] ? trigger : trigger_accepted);
			chk("store", 24'(sample_valid && exp_keep(mode, sample_value, sample_threshold, sample_overflow)),
				24'(sample_store));
			chk("empty", 24'(event_end && !event_has_channels && mode[MB_EMPTY_EN]), 24'(empty_frame_write));
			chk("conv", 24'(convert_req && !mode[MB_OFFLINE]), 24'(convert_start));
		end
		{trigger, trigger_accepted, sample_valid, event_end, convert_req, sw_reset} = 6'h0;
	endtask

	// ====
	// main sequence
	initial begin
		{resetn, sw_reset, trigger, trigger_accepted, sample_valid, sample_overflow, event_end} = 7'h0;
		{event_has_channels, convert_req, buffer_empty, buffer_full} = 4'h0;
		{sample_value, sample_threshold, stored_events, piggyback_type_pins} = 30'h0;
		mode = 16'h4880;
		cnt = '0;
		void'($urandom(32'h755b));
		repeat (6) @(posedge core_clk);
		#1;
		resetn = 1'b1;
		chkmode();
		chk("fc_reset", 24'd350, 24'(fast_clear_window_cycles));
		rdchk("unmapped", 16'h1000, 16'h0);
		rdchk("write_only", ADDR_NEXT_EVENT, 16'h0);
		repeat (3) begin
			v = 16'($urandom);
			wr(ADDR_BASE_HIGH, v);
			wr(ADDR_BASE_LOW, ~v);
			rdchk("base_hi", ADDR_BASE_HIGH, {8'h0, v[7:0]});
			rdchk("base_lo", ADDR_BASE_LOW, {8'h0, ~v[7:0]});
			chk("base_out", {8'h0, v[7:0], ~v[7:0]}, {8'h0, base_address_decoder_high, base_address_decoder_low});
		end
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CHAIN, {14'($urandom), 2'(i)});
			chk("chain", 24'(i), 24'({chain_last, chain_first}));
		end
		wr(ADDR_NEXT_EVENT, 16'($urandom));
		chk("next_event", 24'h1, 24'({next_word_strobe, next_event_strobe}));
		wr(ADDR_NEXT_WORD, 16'($urandom));
		chk("next_word", 24'h2, 24'({next_word_strobe, next_event_strobe}));
		for (int i = 0; i < 5; i++) begin
			v = (i == 4) ? 16'h03f0 : (i == 3) ? 16'h0 : 16'($urandom % 1009);
			wr(ADDR_FAST_CLEAR, v);
			rdchk("fc_n", ADDR_FAST_CLEAR, v);
			chk("fc_cycles", 24'(7000 / 20 + int'(v) * 25 / 16), 24'(fast_clear_window_cycles));
		end
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 16'h0 : 16'($urandom % 32);
			stored_events = (i < 2) ? v[5:0] : 6'($urandom % 32);
			{buffer_empty, buffer_full, piggyback_type_pins} = 6'($urandom);
			wr(ADDR_IRQ_THR, v);
			repeat (4) @(posedge core_clk);
			#1;
			chk("irq", 24'(v != 0 && v[5:0] == stored_events), 24'(irq_req));
			rdchk("thr", ADDR_IRQ_THR, v);
			rdchk("status", ADDR_BUF_STATUS, {8'h0, piggyback_type_pins, 2'b00, buffer_full, buffer_empty});
		end
		for (int i = 0; i < 6; i++) begin
			clrm(16'($urandom));
			setm(16'($urandom));
			if (i[0]) setm(16'h4000);
			else clrm(16'h4004);
			chkmode();
			dp(40);
			rdcnt();
		end
		wr(ADDR_EVCNT_RST, 16'($urandom));
		cnt = '0;
		rdcnt();
		dp(20);
		clrm(16'h4000);
		setm(16'h0004);
		rdcnt();
		clrm(16'h0004);
		setm(16'h4000);
		// long run pushes the count past 16 bits
		trigger = 1'b1;
		repeat (65540) @(posedge core_clk);
		#1;
		trigger = 1'b0;
		cnt = cnt + 24'd65540;
		rdcnt();
		wr(ADDR_ONE_SHOT, 16'($urandom));
		chk("mod_reset", 24'h1, 24'(module_reset));
		mode = 16'h4880;
		cnt = '0;
		rdchk("base_hi", ADDR_BASE_HIGH, 16'h0);
		chkmode();
		rdcnt();
		summarize();
	end

	initial begin
		#1_600_000;
		n_fail++;
		summarize();
	end
endmodule
`default_nettype wire
